// >>> atic_ctrl.sv
`timescale 1ns/100ps
module atic_ctrl (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [atic_pkg::ADDR_W-1:0] i_addr,
  input wire logic [atic_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [atic_pkg::DATA_W-1:0] o_rdata,
  // Trigger sources (timer1 timer_trigger_output/cc1/cc2, timer2 timer_trigger_output/cc1/cc2)
  input wire logic [5:0] i_rule_timer_evt,
  input wire logic i_rule_pin_evt,
  // Trigger sources (timer1 cc3/cc4, timer2 cc3/cc4)
  input wire logic [3:0] i_inj_timer_evt,
  input wire logic i_inj_pin_evt,
  // Converter status, same clock
  input wire logic i_rule_begin,
  input wire logic i_inj_begin,
  input wire logic i_rule_done,
  input wire logic i_inj_done,
  input wire logic i_guard_event,
  input wire logic i_result_read,
  // Converter control
  output logic o_rule_start,
  output logic o_inj_start,
  output logic o_scan_enable,
  output logic o_scan_abort,
  output logic o_guard_single,
  output logic [atic_pkg::C1_GUARD_CH_W-1:0] o_guard_channel,
  // Interrupt
  output logic o_irq
);
  atic_edge_if #(.N(atic_pkg::N_SRC)) trig ();

  // Synchronised trigger edges
  atic_edge_sync #(.N(atic_pkg::N_SRC)) u_edge (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_raw({i_inj_pin_evt, i_inj_timer_evt, i_rule_pin_evt, i_rule_timer_evt}),
    .edge_out(trig.src)
  );

  logic [atic_pkg::C1_GUARD_CH_W-1:0] guard_ch_reg, guard_ch_next;
  logic conv_ie_reg, conv_ie_next;
  logic guard_ie_reg, guard_ie_next;
  logic inj_ie_reg, inj_ie_next;
  logic scan_reg, scan_next;
  logic single_reg, single_next;
  logic [atic_pkg::SEL_W-1:0] rule_sel_reg, rule_sel_next;
  logic [atic_pkg::SEL_W-1:0] inj_sel_reg, inj_sel_next;
  logic rule_en_reg, rule_en_next;
  logic inj_en_reg, inj_en_next;
  logic rule_soft_reg, rule_soft_next;
  logic inj_soft_reg, inj_soft_next;
  logic [atic_pkg::ST_W-1:0] status_reg, status_next;
  logic [atic_pkg::ST_W-1:0] mask_reg, mask_next;
  logic [atic_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic rule_start_reg, rule_start_next;
  logic inj_start_reg, inj_start_next;
  logic abort_reg, abort_next;
  logic irq_reg, irq_next;

  logic wr_ctl1, wr_ctl2, wr_status, wr_mask, rd_status;
  logic rule_ext_evt, inj_ext_evt, rule_soft_set, inj_soft_set;
  logic [atic_pkg::ST_W-1:0] irq_en;
  logic [atic_pkg::ST_W-1:0] events;

  // Address decode
  assign wr_ctl1 = i_wr && (i_addr == atic_pkg::OFS_CTL1);
  assign wr_ctl2 = i_wr && (i_addr == atic_pkg::OFS_CTL2);
  assign wr_status = i_wr && (i_addr == atic_pkg::OFS_STATUS);
  assign wr_mask = i_wr && (i_addr == atic_pkg::OFS_MASK);
  assign rd_status = i_rd && (i_addr == atic_pkg::OFS_STATUS);

  // A write of 1 to a soft start bit is the software trigger event
  assign rule_soft_set = wr_ctl2 && i_wdata[atic_pkg::C2_RULE_SOFT];
  assign inj_soft_set = wr_ctl2 && i_wdata[atic_pkg::C2_INJ_SOFT];

  // Rule source mux: codes 0..6 index the edge vector directly
  // Follows the select being written, so a reselect takes hold at once
  always_comb begin
    rule_ext_evt = 1'b0;
    if (rule_sel_next != atic_pkg::SEL_SOFT) begin
      rule_ext_evt = trig.rise[rule_sel_next];
    end
  end

  // Injected source mux; reserved codes never fire
  always_comb begin
    inj_ext_evt = 1'b0;
    if (inj_sel_next == atic_pkg::SEL_PIN) begin
      inj_ext_evt = trig.rise[atic_pkg::N_SRC-1];
    end else if (inj_sel_next < atic_pkg::INJ_SEL_RSV_LO) begin
      inj_ext_evt = trig.rise[atic_pkg::N_RULE_SRC + 32'(inj_sel_next)];
    end
  end

  // Control one: watchdog scope, scan and interrupt enables
  always_comb begin
    guard_ch_next = guard_ch_reg;
    conv_ie_next = conv_ie_reg;
    guard_ie_next = guard_ie_reg;
    inj_ie_next = inj_ie_reg;
    scan_next = scan_reg;
    single_next = single_reg;
    if (wr_ctl1) begin
      guard_ch_next = i_wdata[atic_pkg::C1_GUARD_CH_LSB +: atic_pkg::C1_GUARD_CH_W];
      conv_ie_next = i_wdata[atic_pkg::C1_CONV_DONE_IE];
      guard_ie_next = i_wdata[atic_pkg::C1_GUARD_IE];
      inj_ie_next = i_wdata[atic_pkg::C1_INJ_DONE_IE];
      scan_next = i_wdata[atic_pkg::C1_SCAN];
      single_next = i_wdata[atic_pkg::C1_SINGLE];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      guard_ch_reg <= atic_pkg::GUARD_CH_RST;
      conv_ie_reg <= 1'b0;
      guard_ie_reg <= 1'b0;
      inj_ie_reg <= 1'b0;
      scan_reg <= 1'b0;
      single_reg <= 1'b0;
    end else begin
      guard_ch_reg <= guard_ch_next;
      conv_ie_reg <= conv_ie_next;
      guard_ie_reg <= guard_ie_next;
      inj_ie_reg <= inj_ie_next;
      scan_reg <= scan_next;
      single_reg <= single_next;
    end
  end

  // Control two: trigger setup and soft start bits
  always_comb begin
    rule_sel_next = rule_sel_reg;
    inj_sel_next = inj_sel_reg;
    rule_en_next = rule_en_reg;
    inj_en_next = inj_en_reg;
    rule_soft_next = rule_soft_reg;
    inj_soft_next = inj_soft_reg;
    if (i_rule_begin) begin
      rule_soft_next = 1'b0;
    end
    if (i_inj_begin) begin
      inj_soft_next = 1'b0;
    end
    if (wr_ctl2) begin
      rule_sel_next = i_wdata[atic_pkg::C2_RULE_SEL_LSB +: atic_pkg::SEL_W];
      inj_sel_next = i_wdata[atic_pkg::C2_INJ_SEL_LSB +: atic_pkg::SEL_W];
      rule_en_next = i_wdata[atic_pkg::C2_RULE_TRIG_EN];
      inj_en_next = i_wdata[atic_pkg::C2_INJ_TRIG_EN];
      // Writing 0 cannot withdraw a pending rule request; new request beats begin
      if (rule_soft_set) begin
        rule_soft_next = 1'b1;
      end
      // Injected request may be set or withdrawn by software
      inj_soft_next = i_wdata[atic_pkg::C2_INJ_SOFT] | (inj_soft_reg & ~i_inj_begin &
        i_wdata[atic_pkg::C2_INJ_SOFT]);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rule_sel_reg <= atic_pkg::SEL_RST;
      inj_sel_reg <= atic_pkg::SEL_RST;
      rule_en_reg <= 1'b0;
      inj_en_reg <= 1'b0;
      rule_soft_reg <= 1'b0;
      inj_soft_reg <= 1'b0;
    end else begin
      rule_sel_reg <= rule_sel_next;
      inj_sel_reg <= inj_sel_next;
      rule_en_reg <= rule_en_next;
      inj_en_reg <= inj_en_next;
      rule_soft_reg <= rule_soft_next;
      inj_soft_reg <= inj_soft_next;
    end
  end

  // Start pulses: one per trigger edge or per software write of 1
  // Gates use the values being written, so one write can set up and fire,
  // and a write that disables the trigger also stops a start in that cycle
  always_comb begin
    rule_start_next = 1'b0;
    inj_start_next = 1'b0;
    if (rule_en_next) begin
      rule_start_next = (rule_sel_next == atic_pkg::SEL_SOFT) ? rule_soft_set
                                                               : rule_ext_evt;
    end
    if (inj_en_next) begin
      inj_start_next = (inj_sel_next == atic_pkg::SEL_SOFT) ? inj_soft_set
                                                             : inj_ext_evt;
    end
  end

  // Sticky status: set beats every clear in the same cycle
  assign events = {i_inj_done, i_rule_done | i_inj_done, i_guard_event};
  assign irq_en = {inj_ie_reg, conv_ie_reg, guard_ie_reg};

  always_comb begin
    status_next = status_reg;
    mask_next = mask_reg;
    if (wr_status) begin
      status_next = status_reg & i_wdata[atic_pkg::ST_W-1:0];
    end
    if (rd_status) begin
      status_next = '0;
    end
    if (i_result_read) begin
      status_next[atic_pkg::ST_CONV_DONE] = 1'b0;
    end
    status_next = status_next | events;
    if (wr_mask) begin
      mask_next = i_wdata[atic_pkg::ST_W-1:0];
    end
  end

  // Interrupt and scan abort, registered
  always_comb begin
    irq_next = |(status_next & irq_en & mask_next);
    abort_next = scan_reg & guard_ie_reg & i_guard_event;
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_next = '0;
    if (i_rd) begin
      unique case (i_addr)
        atic_pkg::OFS_STATUS: rdata_next[atic_pkg::ST_W-1:0] = status_reg;
        atic_pkg::OFS_MASK: rdata_next[atic_pkg::ST_W-1:0] = mask_reg;
        atic_pkg::OFS_CTL1: begin
          rdata_next[atic_pkg::C1_GUARD_CH_LSB +: atic_pkg::C1_GUARD_CH_W] = guard_ch_reg;
          rdata_next[atic_pkg::C1_CONV_DONE_IE] = conv_ie_reg;
          rdata_next[atic_pkg::C1_GUARD_IE] = guard_ie_reg;
          rdata_next[atic_pkg::C1_INJ_DONE_IE] = inj_ie_reg;
          rdata_next[atic_pkg::C1_SCAN] = scan_reg;
          rdata_next[atic_pkg::C1_SINGLE] = single_reg;
        end
        atic_pkg::OFS_CTL2: begin
          rdata_next[atic_pkg::C2_INJ_SEL_LSB +: atic_pkg::SEL_W] = inj_sel_reg;
          rdata_next[atic_pkg::C2_INJ_TRIG_EN] = inj_en_reg;
          rdata_next[atic_pkg::C2_RULE_SEL_LSB +: atic_pkg::SEL_W] = rule_sel_reg;
          rdata_next[atic_pkg::C2_RULE_TRIG_EN] = rule_en_reg;
          rdata_next[atic_pkg::C2_INJ_SOFT] = inj_soft_reg;
          rdata_next[atic_pkg::C2_RULE_SOFT] = rule_soft_reg;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_reg <= atic_pkg::STATUS_RST;
      mask_reg <= atic_pkg::MASK_RST;
      rdata_reg <= '0;
      rule_start_reg <= 1'b0;
      inj_start_reg <= 1'b0;
      abort_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      rule_start_reg <= rule_start_next;
      inj_start_reg <= inj_start_next;
      abort_reg <= abort_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = rdata_reg;
  assign o_rule_start = rule_start_reg;
  assign o_inj_start = inj_start_reg;
  assign o_scan_enable = scan_reg;
  assign o_scan_abort = abort_reg;
  assign o_guard_single = single_reg;
  assign o_guard_channel = guard_ch_reg;
  assign o_irq = irq_reg;
endmodule

// >>> atic_ctrl_asserts.sv
`timescale 1ns/100ps
module atic_ctrl_asserts (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register writes
  input wire logic [atic_pkg::ADDR_W-1:0] i_addr,
  input wire logic [atic_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  // Converter status
  input wire logic i_rule_done,
  input wire logic i_inj_done,
  input wire logic i_guard_event,
  // Control outputs
  input wire logic o_rule_start,
  input wire logic o_inj_start,
  input wire logic o_scan_enable,
  input wire logic o_scan_abort,
  input wire logic o_guard_single,
  input wire logic [atic_pkg::C1_GUARD_CH_W-1:0] o_guard_channel,
  input wire logic o_irq
);
  logic [9:0] c1_reg;
  logic [2:0] mk_reg;
  logic [1:0] ten_reg;
  logic [2:0] ie;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Shadow of software settings, since register bodies are hidden
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      c1_reg <= 10'h000;
      mk_reg <= 3'h7;
      ten_reg <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == atic_pkg::OFS_CTL1) c1_reg <= i_wdata[9:0];
      if (i_addr == atic_pkg::OFS_MASK) mk_reg <= i_wdata[2:0];
      if (i_addr == atic_pkg::OFS_CTL2) ten_reg <= {i_wdata[20], i_wdata[15]};
    end
  end
  // Enables reordered to the status bit layout
  assign ie = {c1_reg[7], c1_reg[5], c1_reg[6]};
  a_single_mirror: assert property (
    $stable(c1_reg)[*3] |-> o_guard_single == c1_reg[9] && o_guard_channel == c1_reg[4:0])
    else $error("guard selection does not follow control one");
  a_scan_mirror: assert property (
    $stable(c1_reg)[*3] |-> o_scan_enable == c1_reg[8])
    else $error("scan enable does not follow control one");
  a_inj_irq: assert property (i_inj_done && ie[2] && mk_reg[2] |=> o_irq)
    else $error("injected done did not raise irq");
  a_guard_irq: assert property (i_guard_event && ie[0] && mk_reg[0] |=> o_irq)
    else $error("guard event did not raise irq");
  a_scan_abort: assert property (i_guard_event && c1_reg[8] && c1_reg[6] |=> o_scan_abort)
    else $error("guard event in scan did not abort");
  a_abort_cause: assert property (
    o_scan_abort |-> $past(i_guard_event) && $past(c1_reg[8]))
    else $error("abort without guard event in scan");
  a_conv_irq: assert property (
    (i_rule_done || i_inj_done) && ie[1] && mk_reg[1] |=> o_irq)
    else $error("conversion done did not raise irq");
  a_rule_gate: assert property (o_rule_start |-> ten_reg[1])
    else $error("rule start while trigger disabled");
  a_inj_gate: assert property (o_inj_start |-> ten_reg[0])
    else $error("injected start while trigger disabled");
  a_start_once: assert property (
    (o_rule_start |=> !o_rule_start) and (o_inj_start |=> !o_inj_start))
    else $error("start pulse longer than one cycle");
  a_irq_quiet: assert property (((ie & mk_reg) == 3'h0)[*3] |-> !o_irq)
    else $error("irq high with every source disabled");
endmodule
bind atic_ctrl atic_ctrl_asserts u_chk (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
  .i_rule_done, .i_inj_done, .i_guard_event, .o_rule_start, .o_inj_start, .o_scan_enable,
  .o_scan_abort, .o_guard_single, .o_guard_channel, .o_irq);

// >>> atic_ctrl_bench.sv
`timescale 1ns/100ps
module atic_ctrl_bench;
  logic i_ref_clk, i_rstn, i_wr, i_rd, fire;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [5:0] ev;
  logic [3:0] idx, len;
  logic [11:0] lvl;
  logic o_rule_start, o_inj_start, o_scan_enable, o_scan_abort, o_guard_single, o_irq;
  logic [4:0] o_guard_channel;
  int err_total = 0;
  int n_checks = 0;
  // Timers and pins; index order matches the select codes, injected from 7
  atic_trig_src src (.i_ref_clk, .i_rstn, .i_fire(fire), .i_idx(idx), .i_len(len), .o_lvl(lvl));
  atic_ctrl uut (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rule_timer_evt(lvl[5:0]), .i_rule_pin_evt(lvl[6]), .i_inj_timer_evt(lvl[10:7]),
    .i_inj_pin_evt(lvl[11]), .i_rule_begin(ev[0]), .i_inj_begin(ev[1]), .i_rule_done(ev[2]),
    .i_inj_done(ev[3]), .i_guard_event(ev[4]), .i_result_read(ev[5]), .o_rule_start,
    .o_inj_start, .o_scan_enable, .o_scan_abort, .o_guard_single, .o_guard_channel, .o_irq);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  task automatic pulse(input int k);
    @(posedge i_ref_clk);
    ev <= 6'h01 << k;
    @(posedge i_ref_clk);
    ev <= 6'h00;
    #1;
  endtask
  task automatic trig(input logic [3:0] i, input logic [3:0] l);
    @(posedge i_ref_clk);
    fire <= 1'b1;
    idx <= i;
    len <= l;
    @(posedge i_ref_clk);
    fire <= 1'b0;
  endtask
  // Window covers the synchroniser delay with margin
  task automatic starts(input logic inj, input int e);
    int c;
    c = 0;
    repeat (10) begin
      #1 c += ((inj ? o_inj_start : o_rule_start) === 1'b1);
      @(posedge i_ref_clk);
    end
    chk(inj ? "inj start" : "rule start", e, c);
  endtask
  task automatic t_reset;
    rd(atic_pkg::OFS_STATUS, 32'h0);
    rd(atic_pkg::OFS_CTL1, 32'h0);
    rd(atic_pkg::OFS_CTL2, 32'h0);
    rd(atic_pkg::OFS_MASK, 32'h7);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ctl1;
    wr(atic_pkg::OFS_CTL1, 32'hFFFFFF0F);
    rd(atic_pkg::OFS_CTL1, 32'h30F);
    chk("single", 1, o_guard_single);
    chk("scan", 1, o_scan_enable);
    chk("channel", 32'hF, o_guard_channel);
    wr(atic_pkg::OFS_CTL1, 32'h0);
    rd(atic_pkg::OFS_CTL1, 32'h0);
    chk("single", 0, o_guard_single);
    chk("scan", 0, o_scan_enable);
    $display("control one test done");
  endtask
  task automatic t_trig;
    for (int s = 0; s < 7; s++) begin
      wr(atic_pkg::OFS_CTL2, 32'h00100000 | (s << 17));
      trig(4'(s), 4'h2);
      starts(1'b0, 1);
    end
    trig(4'h1, 4'h2);
    starts(1'b0, 0);
    wr(atic_pkg::OFS_CTL2, 32'h0);
    trig(4'h6, 4'h2);
    starts(1'b0, 0);
    for (int s = 0; s < 7; s++) begin
      wr(atic_pkg::OFS_CTL2, 32'h00008000 | (s << 12));
      trig(4'((s < 4) ? 7 + s : 11), 4'h6);
      starts(1'b1, (s == 4 || s == 5) ? 0 : 1);
    end
    wr(atic_pkg::OFS_CTL2, 32'h0);
    trig(4'h7, 4'h2);
    starts(1'b1, 0);
    $display("trigger test done");
  endtask
  task automatic t_soft;
    wr(atic_pkg::OFS_CTL2, 32'h005E0000);
    starts(1'b0, 1);
    rd(atic_pkg::OFS_CTL2, 32'h005E0000);
    pulse(0);
    rd(atic_pkg::OFS_CTL2, 32'h001E0000);
    wr(atic_pkg::OFS_CTL2, 32'h0020F000);
    starts(1'b1, 1);
    pulse(1);
    rd(atic_pkg::OFS_CTL2, 32'h0000F000);
    wr(atic_pkg::OFS_CTL2, 32'h00200000);
    starts(1'b1, 0);
    rd(atic_pkg::OFS_CTL2, 32'h00200000);
    wr(atic_pkg::OFS_CTL2, 32'h0);
    rd(atic_pkg::OFS_CTL2, 32'h0);
    $display("soft start test done");
  endtask
  task automatic t_irq;
    wr(atic_pkg::OFS_CTL1, 32'h1E0);
    pulse(4);
    chk("abort", 1, o_scan_abort);
    chk("irq", 1, o_irq);
    rd(atic_pkg::OFS_STATUS, 32'h1);
    @(posedge i_ref_clk);
    #1 chk("irq", 0, o_irq);
    wr(atic_pkg::OFS_MASK, 32'h0);
    pulse(2);
    chk("irq", 0, o_irq);
    wr(atic_pkg::OFS_STATUS, 32'h0);
    rd(atic_pkg::OFS_STATUS, 32'h0);
    pulse(3);
    pulse(5);
    rd(atic_pkg::OFS_STATUS, 32'h4);
    // Only the injected enable, so the conversion-done bit cannot mask a fault
    wr(atic_pkg::OFS_CTL1, 32'h080);
    wr(atic_pkg::OFS_MASK, 32'h7);
    pulse(3);
    chk("irq", 1, o_irq);
    wr(atic_pkg::OFS_STATUS, 32'h0);
    pulse(4);
    wr(atic_pkg::OFS_STATUS, 32'h7);
    rd(atic_pkg::OFS_STATUS, 32'h1);
    wr(atic_pkg::OFS_CTL1, 32'h020);
    pulse(2);
    chk("irq", 1, o_irq);
    rd(atic_pkg::OFS_STATUS, 32'h2);
    wr(atic_pkg::OFS_CTL1, 32'h0);
    pulse(4);
    chk("abort", 0, o_scan_abort);
    chk("irq", 0, o_irq);
    $display("interrupt test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // 20 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rstn, i_wr, i_rd, fire, ev, idx, len, i_addr, i_wdata} = '0;
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset;
    t_ctl1;
    t_trig;
    t_soft;
    t_irq;
    close_out;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    err_total++;
    close_out;
  end
endmodule

// >>> atic_edge_if.sv
`timescale 1ns/100ps
interface atic_edge_if #(parameter int N = 12);
  // One-cycle rise pulses, already in the control clock domain
  logic [N-1:0] rise;
  modport src (output rise);
  modport dst (input rise);
endinterface

// >>> atic_edge_sync.sv
`timescale 1ns/100ps
module atic_edge_sync #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Raw trigger levels from timers and pins
  input wire logic [N-1:0] i_raw,
  // Rise pulses towards the control logic
  atic_edge_if.src edge_out
);
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] prev_reg;
  logic [N-1:0] meta_next;
  logic [N-1:0] sync_next;
  logic [N-1:0] prev_next;

  // Per-source two-stage synchroniser and edge history
  for (genvar g = 0; g < N; g++) begin : g_src
    always_comb begin
      meta_next[g] = i_raw[g];
      sync_next[g] = meta_reg[g];
      prev_next[g] = sync_reg[g];
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        meta_reg[g] <= 1'b0;
        sync_reg[g] <= 1'b0;
        prev_reg[g] <= 1'b0;
      end else begin
        meta_reg[g] <= meta_next[g];
        sync_reg[g] <= sync_next[g];
        prev_reg[g] <= prev_next[g];
      end
    end

    // Rising edge only, so a long trigger level yields one event
    assign edge_out.rise[g] = sync_reg[g] & ~prev_reg[g];
  end
endmodule

// >>> atic_pkg.sv
package atic_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL2 = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h30;

  // Status / mask field positions
  localparam int ST_GUARD = 0;
  localparam int ST_CONV_DONE = 1;
  localparam int ST_INJ_DONE = 2;
  localparam int ST_W = 3;

  // Control one field positions
  localparam int C1_GUARD_CH_LSB = 0;
  localparam int C1_GUARD_CH_W = 5;
  localparam int C1_CONV_DONE_IE = 5;
  localparam int C1_GUARD_IE = 6;
  localparam int C1_INJ_DONE_IE = 7;
  localparam int C1_SCAN = 8;
  localparam int C1_SINGLE = 9;

  // Control two field positions
  localparam int C2_INJ_SEL_LSB = 12;
  localparam int C2_INJ_TRIG_EN = 15;
  localparam int C2_RULE_SEL_LSB = 17;
  localparam int C2_RULE_TRIG_EN = 20;
  localparam int C2_INJ_SOFT = 21;
  localparam int C2_RULE_SOFT = 22;
  localparam int SEL_W = 3;

  // Reset values
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h7;
  localparam logic [C1_GUARD_CH_W-1:0] GUARD_CH_RST = 5'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

  // Trigger select codes
  localparam logic [SEL_W-1:0] SEL_PIN = 3'h6;
  localparam logic [SEL_W-1:0] SEL_SOFT = 3'h7;
  localparam logic [SEL_W-1:0] INJ_SEL_RSV_LO = 3'h4;
  localparam logic [SEL_W-1:0] INJ_SEL_RSV_HI = 3'h5;

  // Trigger source vector layout: rule sources first, then injected
  localparam int N_RULE_SRC = 7;
  localparam int N_INJ_SRC = 5;
  localparam int N_SRC = N_RULE_SRC + N_INJ_SRC;
  localparam int SYNC_STAGES = 2;
endpackage

// >>> atic_trig_src.sv
`timescale 1ns/100ps
module atic_trig_src (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Command: source index and how long its level stays high
  input wire logic i_fire,
  input wire logic [3:0] i_idx,
  input wire logic [3:0] i_len,
  // Trigger levels
  output logic [11:0] o_lvl
);
  logic [11:0] lvl_reg;
  logic [3:0] cnt_reg;
  // Long levels mimic slow sources; only the rising edge may count
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_reg <= 12'h000;
      cnt_reg <= 4'h0;
    end else if (i_fire) begin
      lvl_reg <= 12'h001 << i_idx;
      cnt_reg <= i_len;
    end else if (cnt_reg > 4'h1) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      lvl_reg <= 12'h000;
      cnt_reg <= 4'h0;
    end
  end
  assign o_lvl = lvl_reg;
endmodule
